// ### pls_fifo.sv
// small synchronous fifo with valid/ready on both sides and a fill level
module pls_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// occupancy
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [LW-1:0] count_r, count_nxt;
	logic push, pop;

	// full and empty come straight from the count
	assign in_ready = (count_r != LW'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign level = count_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer wrap works for any depth, not only powers of two
	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		if (push) begin
			wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr_r + 1'b1);
		end
		if (pop) begin
			rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr_r + 1'b1);
		end
		if (push && !pop) begin
			count_nxt = LW'(count_r + 1'b1);
		end else if (pop && !push) begin
			count_nxt = LW'(count_r - 1'b1);
		end
	end

	// storage has no reset; only pointers and count carry state
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

endmodule : pls_fifo

// ### pls_highway_sink.sv
// pcm highway sink model that takes converted samples from the law selector
module pls_highway_sink (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// pacing set by the bench
	input wire logic stall,
	input wire logic slow,
	// sample stream from the selector
	input wire logic out_valid,
	output logic out_ready = 1'b0,
	input wire logic [4:0] out_channel,
	input wire logic out_dir,
	input wire logic out_law,
	input wire logic [7:0] out_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] seen[$];
	// ready is registered; slow mode toggles it so back pressure lands on every other beat
	always @(posedge clock) begin
		if (!rstn || stall) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= slow ? !out_ready : 1'b1;
		end
	end
	// keep accepted samples in arrival order for the bench to judge
	always @(posedge clock) begin
		if (rstn && out_valid && out_ready) begin
			seen.push_back({out_channel, out_dir, out_law, out_data});
		end
	end
endmodule : pls_highway_sink

// ### pls_law_select.sv
// per-channel companding law selection and a/mu transcoding with apb registers
// How it works
// - per-channel mode uses channel bits 7..5
// - global mode uses global bits 2..0
// - global mode disabled channel: global bypass law
// - global mode near side follows global near bit
// - global mode far side follows global far bit
// - register, inband or serial source disables conversion
// - both laws switch to bypass law while disabled
// - channel law bits ignored in global mode
// - per-channel disabled channel: its bypass law
// - per-channel near side follows channel near bit
// - per-channel far side follows channel far bit
// - conversion disable overrides near and far laws
// - law registers write protected, reset to zero
// - thirty-two channel registers at 40h to 5fh
// - processor-only bit masks hardware disable sources
module pls_law_select #(
	parameter int CHANNELS = pls_pkg::PLS_CHANNELS,
	parameter int FIFO_DEPTH = pls_pkg::PLS_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// apb register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// hardware conversion disable source (asynchronous pin)
	input wire logic serial_conv_disable,
	// incoming samples
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [4:0] in_channel,
	input wire logic in_dir,
	input wire logic in_inband_command_code,
	input wire logic [7:0] in_data,
	// outgoing samples
	output logic out_valid,
	input wire logic out_ready,
	output logic [4:0] out_channel,
	output logic out_dir,
	output logic out_law,
	output logic [7:0] out_data
);
	localparam int FW = 15;
	localparam int LW = $clog2(FIFO_DEPTH+1);
	// ***************************************************************
	// g.711 helpers
	// ***************************************************************
	// code to sign/magnitude linear, both laws on a 16-bit scale
	function automatic logic [15:0] pls_to_lin(input logic [7:0] code, input logic law);
		logic [7:0] x;
		logic [2:0] e;
		logic [15:0] m;
		logic neg;
		if (law == pls_pkg::PLS_LAW_A) begin
			x = code ^ pls_pkg::PLS_A_XOR;
			neg = ~x[7];
			e = x[6:4];
			if (e == 3'h0) begin
				m = {8'h00, x[3:0], 4'h8};
			end else begin
				m = {7'h00, 1'b1, x[3:0], 4'h8} << (e - 3'h1);
			end
		end else begin
			x = ~code;
			neg = x[7];
			e = x[6:4];
			m = 16'({8'h00, 1'b1, x[3:0], 3'h4} << e) - pls_pkg::PLS_MU_BIAS;
		end
		return {neg, m[14:0]};
	endfunction : pls_to_lin
	// sign/magnitude linear back to a code of the given law
	function automatic logic [7:0] pls_to_code(input logic [15:0] lin, input logic law);
		logic [14:0] mag;
		logic [15:0] b;
		logic [2:0] e;
		logic [3:0] man;
		mag = lin[14:0];
		e = 3'h0;
		b = 16'h0000;
		if (law == pls_pkg::PLS_LAW_A) begin
			for (int i = 8; i < 15; i++) begin
				if (mag[i]) begin
					e = 3'(i - 7);
				end
			end
			man = (e == 3'h0) ? mag[7:4] : 4'(mag >> (4'(e) + 4'h3));
			return {~lin[15], e, man} ^ pls_pkg::PLS_A_XOR;
		end
		// mu-law clips before the bias so the sum never overflows
		b = {1'b0, (mag > pls_pkg::PLS_MU_CLIP) ? pls_pkg::PLS_MU_CLIP : mag} + pls_pkg::PLS_MU_BIAS;
		for (int i = 8; i < 15; i++) begin
			if (b[i]) begin
				e = 3'(i - 7);
			end
		end
		man = 4'(b >> (4'(e) + 4'h3));
		return ~{lin[15], e, man};
	endfunction : pls_to_code
	// effective {disabled, input law, output law} of one sample
	function automatic logic [2:0] pls_eff(input logic [7:0] g, input logic [7:0] c, input logic dir,
		input logic hw_dis);
		logic dis, near, far, byp;
		dis = c[pls_pkg::PLS_C_CONV_DIS] | (~c[pls_pkg::PLS_C_PROC_ONLY] & hw_dis);
		if (g[pls_pkg::PLS_G_CHAN_SEL]) begin
			near = c[pls_pkg::PLS_C_NEAR];
			far = c[pls_pkg::PLS_C_FAR];
			byp = c[pls_pkg::PLS_C_BYPASS];
		end else begin
			near = g[pls_pkg::PLS_G_NEAR];
			far = g[pls_pkg::PLS_G_FAR];
			byp = g[pls_pkg::PLS_G_BYPASS];
		end
		if (dis) begin
			return {1'b1, byp, byp};
		end
		// receive runs far to near, send runs near to far
		return {1'b0, (dir == pls_pkg::PLS_DIR_SEND) ? near : far, (dir == pls_pkg::PLS_DIR_SEND) ? far : near};
	endfunction : pls_eff
	// ***************************************************************
	// register file
	// ***************************************************************
	logic [7:0] guard_r, guard_nxt, global_r, global_nxt;
	logic [7:0] chan_r [CHANNELS], chan_nxt [CHANNELS];
	logic [31:0] prdata_r, prdata_nxt;
	logic [9:0] idx;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, unlocked, is_chan, commit;
	logic [4:0] last_channel_r, last_channel_nxt;
	logic last_dis_r, last_dis_nxt, last_in_law_r, last_in_law_nxt, last_out_law_r, last_out_law_nxt;

	assign idx = paddr[11:2];
	assign unlocked = (guard_r == pls_pkg::PLS_GUARD_KEY);
	assign is_chan = (idx >= pls_pkg::PLS_IDX_CHAN_FIRST) && (idx <= pls_pkg::PLS_IDX_CHAN_LAST);
	assign commit = psel && penable && pready_r;

	// decode in setup, answer in the first access cycle, commit on that edge
	always_comb begin
		guard_nxt = guard_r;
		global_nxt = global_r;
		chan_nxt = chan_r;
		prdata_nxt = prdata_r;
		pready_nxt = psel && !penable;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			if (paddr[1:0] != 2'h0) begin
				pslverr_nxt = 1'b1;
			end else if (idx == pls_pkg::PLS_IDX_GUARD) begin
				prdata_nxt = {24'h00_0000, guard_r};
			end else if (idx == pls_pkg::PLS_IDX_GLOBAL) begin
				prdata_nxt = {24'h00_0000, global_r};
				pslverr_nxt = pwrite && !unlocked;
			end else if (is_chan) begin
				prdata_nxt = {24'h00_0000, chan_r[idx[4:0]]};
				pslverr_nxt = pwrite && !unlocked;
			end else if (idx == pls_pkg::PLS_IDX_STATUS) begin
				prdata_nxt = {19'h0_0000, last_channel_r, 4'h0, last_out_law_r, last_in_law_r, last_dis_r, unlocked};
				pslverr_nxt = pwrite;
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		// a refused write was flagged in setup and changes nothing here
		if (commit && pwrite && !pslverr_r) begin
			if (idx == pls_pkg::PLS_IDX_GUARD) begin
				guard_nxt = pwdata[7:0];
			end else if (idx == pls_pkg::PLS_IDX_GLOBAL) begin
				global_nxt = {4'h0, pwdata[3:0]};
			end else if (is_chan) begin
				chan_nxt[idx[4:0]] = pwdata[7:0];
			end
		end
	end
	// register state, reset values hold until the first guarded write
	always_ff @(posedge clock) begin
		if (!rstn) begin
			guard_r <= pls_pkg::PLS_GUARD_RST;
			global_r <= pls_pkg::PLS_GLOBAL_RST;
			for (int i = 0; i < CHANNELS; i++) begin
				chan_r[i] <= pls_pkg::PLS_CHAN_RST;
			end
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			guard_r <= guard_nxt;
			global_r <= global_nxt;
			chan_r <= chan_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	// ***************************************************************
	// sample path
	// ***************************************************************
	logic ser_meta_r, ser_meta_nxt, ser_sync_r, ser_sync_nxt, in_ready_r, in_ready_nxt;
	logic s_valid_r, s_valid_nxt, s_dir_r, s_dir_nxt, s_law_r, s_law_nxt;
	logic s_in_law_r, s_in_law_nxt, s_dis_r, s_dis_nxt;
	logic [4:0] s_channel_r, s_channel_nxt;
	logic [7:0] s_data_r, s_data_nxt;
	logic out_valid_r, out_valid_nxt, out_dir_r, out_dir_nxt, out_law_r, out_law_nxt;
	logic [4:0] out_channel_r, out_channel_nxt;
	logic [7:0] out_data_r, out_data_nxt;
	logic [2:0] eff;
	logic accept, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [FW-1:0] fifo_out_data;
	logic [LW-1:0] fifo_level;

	assign eff = pls_eff(global_r, chan_r[in_channel], in_dir, in_inband_command_code | ser_sync_r);
	assign accept = in_valid && in_ready_r && (!s_valid_r || fifo_in_ready);
	assign fifo_out_ready = !out_valid_r || out_ready;

	// laws are looked up per sample, so a register change hits the next sample
	always_comb begin
		ser_meta_nxt = serial_conv_disable;
		ser_sync_nxt = ser_meta_r;
		s_valid_nxt = s_valid_r && !fifo_in_ready;
		s_channel_nxt = s_channel_r;
		s_dir_nxt = s_dir_r;
		s_law_nxt = s_law_r;
		s_in_law_nxt = s_in_law_r;
		s_dis_nxt = s_dis_r;
		s_data_nxt = s_data_r;
		last_channel_nxt = last_channel_r;
		last_dis_nxt = last_dis_r;
		last_in_law_nxt = last_in_law_r;
		last_out_law_nxt = last_out_law_r;
		if (accept) begin
			s_valid_nxt = 1'b1;
			s_channel_nxt = in_channel;
			s_dir_nxt = in_dir;
			s_dis_nxt = eff[2];
			s_in_law_nxt = eff[1];
			s_law_nxt = eff[0];
			s_data_nxt = (eff[1] != eff[0]) ? pls_to_code(pls_to_lin(in_data, eff[1]), eff[0]) : in_data;
			last_channel_nxt = in_channel;
			last_dis_nxt = eff[2];
			last_in_law_nxt = eff[1];
			last_out_law_nxt = eff[0];
		end
		// stage plus fifo may hold up to depth words; two slots cover the ready lag
		in_ready_nxt = (LW'(fifo_level) + LW'(s_valid_nxt)) <= LW'(FIFO_DEPTH - 2);
		out_valid_nxt = out_valid_r && !out_ready;
		out_channel_nxt = out_channel_r;
		out_dir_nxt = out_dir_r;
		out_law_nxt = out_law_r;
		out_data_nxt = out_data_r;
		if (fifo_out_valid && fifo_out_ready) begin
			out_valid_nxt = 1'b1;
			{out_channel_nxt, out_dir_nxt, out_law_nxt, out_data_nxt} = fifo_out_data;
		end
	end
	// sample path state
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ser_meta_r <= 1'b0;
			ser_sync_r <= 1'b0;
			s_valid_r <= 1'b0;
			s_channel_r <= 5'h00;
			s_dir_r <= 1'b0;
			s_law_r <= 1'b0;
			s_in_law_r <= 1'b0;
			s_dis_r <= 1'b0;
			s_data_r <= 8'h00;
			last_channel_r <= 5'h00;
			last_dis_r <= 1'b0;
			last_in_law_r <= 1'b0;
			last_out_law_r <= 1'b0;
			in_ready_r <= 1'b0;
			out_valid_r <= 1'b0;
			out_channel_r <= 5'h00;
			out_dir_r <= 1'b0;
			out_law_r <= 1'b0;
			out_data_r <= 8'h00;
		end else begin
			ser_meta_r <= ser_meta_nxt;
			ser_sync_r <= ser_sync_nxt;
			s_valid_r <= s_valid_nxt;
			s_channel_r <= s_channel_nxt;
			s_dir_r <= s_dir_nxt;
			s_law_r <= s_law_nxt;
			s_in_law_r <= s_in_law_nxt;
			s_dis_r <= s_dis_nxt;
			s_data_r <= s_data_nxt;
			last_channel_r <= last_channel_nxt;
			last_dis_r <= last_dis_nxt;
			last_in_law_r <= last_in_law_nxt;
			last_out_law_r <= last_out_law_nxt;
			in_ready_r <= in_ready_nxt;
			out_valid_r <= out_valid_nxt;
			out_channel_r <= out_channel_nxt;
			out_dir_r <= out_dir_nxt;
			out_law_r <= out_law_nxt;
			out_data_r <= out_data_nxt;
		end
	end
	// buffer between the transcoder and the output register
	pls_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rstn(rstn),
		.in_valid(s_valid_r),
		.in_ready(fifo_in_ready),
		.in_data({s_channel_r, s_dir_r, s_law_r, s_data_r}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);
	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_channel = out_channel_r;
	assign out_dir = out_dir_r;
	assign out_law = out_law_r;
	assign out_data = out_data_r;
	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_reset_values: assert property ($past(!rstn) |-> global_r == pls_pkg::PLS_GLOBAL_RST &&
		chan_r[0] == pls_pkg::PLS_CHAN_RST && !unlocked) else $error("law registers not zero after reset");
	chk_locked_write: assert property (commit && pwrite && !unlocked && idx == pls_pkg::PLS_IDX_GLOBAL
		|=> global_r == $past(global_r)) else $error("protected register changed while locked");
	chk_global_near: assert property (accept && !global_r[pls_pkg::PLS_G_CHAN_SEL] && !eff[2]
		&& in_dir == pls_pkg::PLS_DIR_RECV |=> s_law_r == $past(global_r[pls_pkg::PLS_G_NEAR]))
		else $error("global near law not applied");
	chk_chan_far: assert property (accept && global_r[pls_pkg::PLS_G_CHAN_SEL] && !eff[2]
		&& in_dir == pls_pkg::PLS_DIR_SEND |=> s_law_r == $past(chan_r[in_channel][pls_pkg::PLS_C_FAR]))
		else $error("channel far law not applied");
	chk_bypass_law: assert property (accept && chan_r[in_channel][pls_pkg::PLS_C_CONV_DIS]
		|=> s_dis_r && s_law_r == s_in_law_r) else $error("disabled channel not on bypass law");
	chk_proc_only: assert property (accept && chan_r[in_channel][pls_pkg::PLS_C_PROC_ONLY]
		&& !chan_r[in_channel][pls_pkg::PLS_C_CONV_DIS] |=> !s_dis_r) else $error("hardware source leaked");
	chk_inband_dis: assert property (accept && in_inband_command_code
		&& !chan_r[in_channel][pls_pkg::PLS_C_PROC_ONLY] |=> s_dis_r) else $error("inband disable ignored");
	chk_same_pass: assert property (accept && eff[1] == eff[0]
		|=> s_data_r == $past(in_data)) else $error("equal laws altered sample");
	chk_no_overrun: assert property (s_valid_r |-> fifo_in_ready) else $error("stage blocked by full fifo");
	chk_apb_answer: assert property (psel && !penable |=> pready_r ##1 !pready_r)
		else $error("apb answer timing wrong");
	cov_chan_mode: cover property (accept && global_r[pls_pkg::PLS_G_CHAN_SEL]);
	cov_transcode: cover property (accept && eff[1] != eff[0]);
	cov_disabled: cover property (accept && eff[2]);
	cov_fifo_stall: cover property (!in_ready_r && in_valid);

endmodule : pls_law_select

// ### pls_law_select_tb.sv
// self-checking bench for the companding law selector
module pls_law_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] GLB = pls_pkg::PLS_IDX_GLOBAL;
	localparam logic [9:0] CH0 = pls_pkg::PLS_IDX_CHAN_FIRST;
	localparam logic [9:0] GRD = pls_pkg::PLS_IDX_GUARD;
	localparam logic R = pls_pkg::PLS_DIR_RECV;
	localparam logic S = pls_pkg::PLS_DIR_SEND;
	localparam logic A = pls_pkg::PLS_LAW_A;
	localparam logic M = pls_pkg::PLS_LAW_MU;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, in_ready, out_valid, out_ready, out_dir, out_law;
	logic serial_conv_disable = 1'b0, in_valid = 1'b0, in_dir = 1'b0, in_inband_command_code = 1'b0;
	logic [4:0] in_channel = 5'h00, out_channel;
	logic [7:0] in_data = 8'h00, out_data;
	logic stall = 1'b0, slow = 1'b0;
	int fail_count = 0, comparisons = 0, cycles = 0;

	// 200 mhz clock
	always #2.5 clock = ~clock;

	pls_law_select dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_conv_disable(serial_conv_disable), .in_valid(in_valid), .in_ready(in_ready),
		.in_channel(in_channel), .in_dir(in_dir), .in_inband_command_code(in_inband_command_code),
		.in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_channel(out_channel),
		.out_dir(out_dir), .out_law(out_law), .out_data(out_data));

	pls_highway_sink sink (.clock(clock), .rstn(rstn), .stall(stall), .slow(slow), .out_valid(out_valid),
		.out_ready(out_ready), .out_channel(out_channel), .out_dir(out_dir), .out_law(out_law),
		.out_data(out_data));

	// ***************************************************************
	// shared tasks
	// ***************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo, input logic [7:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, lo};
		pwdata <= {24'h0, wd};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (!pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic eerr);
		apb(1'b1, idx, 2'b00, d);
		check({31'h0, err}, {31'h0, eerr}, "write response");
	endtask : wr

	task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 2'b00, 8'h00);
		check(rd, {24'h0, exp}, "read data");
	endtask : rdchk

	// offer one sample, then judge what reaches the far highway
	task automatic send(input logic [4:0] ch, input logic dir, input logic ib, input logic [7:0] d,
		input logic law, input logic [7:0] ed);
		logic [14:0] got;
		@(posedge clock);
		in_channel <= ch;
		in_dir <= dir;
		in_inband_command_code <= ib;
		in_data <= d;
		in_valid <= 1'b1;
		do @(posedge clock); while (!in_ready);
		in_valid <= 1'b0;
		in_inband_command_code <= 1'b0;
		in_data <= ~d;
		while (sink.seen.size() == 0) @(posedge clock);
		got = sink.seen.pop_front();
		check({17'h0, got}, {17'h0, ch, dir, law, ed}, "sample out");
	endtask : send

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_regs();
		rdchk(GLB, 8'h00);
		rdchk(CH0 + 10'h01f, 8'h00);
		wr(CH0 + 10'h005, 8'he0, 1'b1);
		rdchk(CH0 + 10'h005, 8'h00);
		wr(GLB, 8'h0f, 1'b1);
		rdchk(GLB, 8'h00);
		wr(pls_pkg::PLS_IDX_STATUS, 8'hff, 1'b1);
		wr(10'h020, 8'h00, 1'b1);
		apb(1'b0, GLB, 2'b01, 8'h00);
		check({31'h0, err}, 32'h1, "misaligned");
		wr(GRD, pls_pkg::PLS_GUARD_KEY, 1'b0);
		wr(CH0 + 10'h005, 8'he0, 1'b0);
		rdchk(CH0 + 10'h005, 8'he0);
		wr(GRD, 8'h00, 1'b0);
		wr(CH0 + 10'h005, 8'h00, 1'b1);
		rdchk(CH0 + 10'h005, 8'he0);
		wr(GRD, pls_pkg::PLS_GUARD_KEY, 1'b0);
	endtask : t_regs

	// channel bits on channel 3 must not matter while global mode holds
	task automatic t_global();
		wr(CH0 + 10'h003, 8'he0, 1'b0);
		wr(GLB, 8'h02, 1'b0);
		send(5'h03, R, 1'b0, 8'hff, A, 8'hd5);
		wr(GLB, 8'h01, 1'b0);
		send(5'h03, S, 1'b0, 8'hff, A, 8'hd5);
		wr(GLB, 8'h00, 1'b0);
		send(5'h03, R, 1'b0, 8'h2a, M, 8'h2a);
	endtask : t_global

	task automatic t_disable();
		wr(GLB, 8'h04, 1'b0);
		send(5'h09, R, 1'b1, 8'h3c, A, 8'h3c);
		send(5'h09, R, 1'b0, 8'h3c, M, 8'h3c);
		serial_conv_disable <= 1'b1;
		repeat (3) @(posedge clock);
		send(5'h09, S, 1'b0, 8'h3c, A, 8'h3c);
		wr(CH0 + 10'h009, 8'h01, 1'b0);
		send(5'h09, S, 1'b1, 8'h3c, M, 8'h3c);
		wr(CH0 + 10'h009, 8'h11, 1'b0);
		send(5'h09, S, 1'b0, 8'h3c, A, 8'h3c);
		serial_conv_disable <= 1'b0;
		wr(GLB, 8'h06, 1'b0);
		send(5'h09, R, 1'b0, 8'hff, A, 8'hff);
	endtask : t_disable

	task automatic t_chan();
		wr(GLB, 8'h08, 1'b0);
		send(5'h05, R, 1'b0, 8'h11, A, 8'h11);
		send(5'h00, R, 1'b0, 8'h11, M, 8'h11);
		wr(CH0 + 10'h01f, 8'h40, 1'b0);
		send(5'h1f, R, 1'b0, 8'hff, A, 8'hd5);
		wr(CH0 + 10'h01f, 8'h20, 1'b0);
		send(5'h1f, S, 1'b0, 8'hff, A, 8'hd5);
		wr(CH0 + 10'h01f, 8'h90, 1'b0);
		send(5'h1f, R, 1'b0, 8'h77, A, 8'h77);
		wr(CH0 + 10'h01f, 8'h60, 1'b0);
		send(5'h1f, S, 1'b1, 8'h77, M, 8'h77);
		// status shows channel 31, disabled, mu-law both ways, unlocked
		apb(1'b0, pls_pkg::PLS_IDX_STATUS, 2'b00, 8'h00);
		check(rd, 32'h0000_1f03, "last sample status");
	endtask : t_chan

	// the sink stalls for 40 cycles while the path fills and refuses, then drains slowly; order must survive
	task automatic t_fifo();
		int n;
		logic [14:0] got;
		wr(GLB, 8'h00, 1'b0);
		stall <= 1'b1;
		in_valid <= 1'b1;
		in_dir <= R;
		in_data <= 8'h00;
		in_channel <= 5'h00;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			if (in_ready) begin
				n++;
				in_data <= n[7:0];
				in_channel <= n[4:0];
			end
		end
		in_valid <= 1'b0;
		check({31'h0, (n > 5 && n < 12)}, 32'h1, "fill depth");
		slow <= 1'b1;
		stall <= 1'b0;
		for (int j = 0; j < n; j++) begin
			while (sink.seen.size() == 0) @(posedge clock);
			got = sink.seen.pop_front();
			check({17'h0, got}, {17'h0, j[4:0], R, M, j[7:0]}, "drain order");
		end
		repeat (4) @(posedge clock);
		check({31'h0, out_valid}, 32'h0, "drained");
	endtask : t_fifo

	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// a hang counts as a mismatch and closes the run
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		t_regs();
		t_global();
		t_disable();
		t_chan();
		t_fifo();
		print_verdict();
	end
endmodule : pls_law_select_tb

// ### pls_pkg.sv
// shared constants for the companding law selector
package pls_pkg;

	// ***************************************************************
	// register map (word indexes, byte address is four times index)
	// ***************************************************************
	localparam logic [9:0] PLS_IDX_GUARD = 10'h001;
	localparam logic [9:0] PLS_IDX_GLOBAL = 10'h03f;
	localparam logic [9:0] PLS_IDX_CHAN_FIRST = 10'h040;
	localparam logic [9:0] PLS_IDX_CHAN_LAST = 10'h05f;
	localparam logic [9:0] PLS_IDX_STATUS = 10'h060;

	// ***************************************************************
	// reset values and the write guard key
	// ***************************************************************
	localparam logic [7:0] PLS_GUARD_KEY = 8'h95;
	localparam logic [7:0] PLS_GUARD_RST = 8'h00;
	localparam logic [7:0] PLS_GLOBAL_RST = 8'h00;
	localparam logic [7:0] PLS_CHAN_RST = 8'h00;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int PLS_G_CHAN_SEL = 3;
	localparam int PLS_G_BYPASS = 2;
	localparam int PLS_G_NEAR = 1;
	localparam int PLS_G_FAR = 0;
	localparam int PLS_C_BYPASS = 7;
	localparam int PLS_C_NEAR = 6;
	localparam int PLS_C_FAR = 5;
	localparam int PLS_C_CONV_DIS = 4;
	localparam int PLS_C_PROC_ONLY = 0;

	// ***************************************************************
	// encodings and sizes
	// ***************************************************************
	localparam logic PLS_LAW_MU = 1'b0;
	localparam logic PLS_LAW_A = 1'b1;
	localparam logic PLS_DIR_RECV = 1'b0;
	localparam logic PLS_DIR_SEND = 1'b1;
	localparam int PLS_CHANNELS = 32;
	localparam int PLS_FIFO_DEPTH = 8;
	localparam logic [7:0] PLS_A_XOR = 8'h55;
	localparam logic [15:0] PLS_MU_BIAS = 16'h0084;
	localparam logic [14:0] PLS_MU_CLIP = 15'h7f7b;

endpackage : pls_pkg
